//--- common/usb_setup_ep_defs.svh
`ifndef USB_SETUP_EP_DEFS_SVH
`define USB_SETUP_EP_DEFS_SVH

// Local bus register offsets
`define OFS_ENDPOINT_DATA_PORT 8'h05
`define OFS_ENDPOINT_STATUS_LOW 8'h06
`define OFS_SETUP_INDEX_LOW 8'h44
`define OFS_SETUP_INDEX_HIGH 8'h45
`define OFS_SETUP_LENGTH_LOW 8'h46
`define OFS_SETUP_LENGTH_HIGH 8'h47

// Field positions in endpoint_status_low
`define BIT_BUF_FULL 7
`define BIT_BUF_EMPTY 6
`define BIT_NAK_OUT 5
`define BIT_SHORT_PKT 4
`define BIT_PKT_RECEIVED 3
`define BIT_PKT_SENT 2
`define BIT_OUT_TOKEN 1
`define BIT_IN_TOKEN 0

// Reset values
`define RST_SETUP_BYTE 8'h00
`define RST_STICKY 6'h00
`define RST_ENDPOINT_DATA 16'h0000
`define RST_UNMAPPED 16'h0000

// Structure sizes
`define NUM_ENDPOINTS 4
`define STICKY_BITS 6

`endif

//--- common/usb_setup_ep_pkg.sv
`default_nettype none

package usb_setup_ep_pkg;

  typedef logic [1:0] ep_num_type;
  typedef logic [10:0] pkt_len_type;

  // Local bus pins as seen at the device boundary
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] addr;
    logic [15:0] data;
  } lbus_in_type;

  // One cycle event report from the protocol engine
  typedef struct packed {
    ep_num_type ep;
    logic in_token;
    logic out_token;
    logic ping;
    logic high_speed;
    logic data_rx;
    logic data_tx;
    pkt_len_type pkt_len;
  } usb_event_type;

  // Bytes 4 to 7 of a freshly received setup packet
  typedef struct packed {
    logic valid;
    logic [15:0] index;
    logic [15:0] length;
  } setup_capture_type;

  // Per endpoint configuration held elsewhere in the device
  typedef struct packed {
    logic dir_in;
    logic nak_out_mode;
    pkt_len_type max_packet_size;
  } ep_config_type;

  // Currently visible buffer of one endpoint, from the buffer manager
  typedef struct packed {
    logic local_avail;
    pkt_len_type count;
  } buf_status_type;

  // Word on its way from the data port to the packet buffer
  typedef struct packed {
    ep_num_type ep;
    logic two_bytes;
    logic [15:0] data;
  } fifo_word_type;

endpackage

`default_nettype wire

//--- hw/usb_setup_ep_regs.sv
`default_nettype none

`include "usb_setup_ep_defs.svh"

module usb_setup_ep_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire usb_setup_ep_pkg::lbus_in_type lbus,
  input wire logic bus16,
  input wire usb_setup_ep_pkg::ep_num_type page_sel,
  input wire logic dma_enable,
  input wire usb_setup_ep_pkg::ep_num_type dma_ep,
  input wire usb_setup_ep_pkg::ep_config_type [3:0] ep_cfg,
  input wire usb_setup_ep_pkg::buf_status_type [3:0] buf_stat,
  input wire usb_setup_ep_pkg::usb_event_type usb_evt,
  input wire usb_setup_ep_pkg::setup_capture_type setup_cap,
  input wire logic [3:0] rsp_set_nak,
  input wire logic [3:0] rsp_clr_nak,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [15:0] rx_data,
  output logic [15:0] data_out,
  output logic data_oe_n,
  output logic bus_wait,
  output logic tx_valid,
  output usb_setup_ep_pkg::fifo_word_type tx_word,
  output logic rx_ready,
  output usb_setup_ep_pkg::ep_num_type rx_ep,
  output logic [3:0] nak_out
);

  ////////////////////////////////////////////////////////////////////////////
  // State of the whole block

  typedef struct packed {
    usb_setup_ep_pkg::lbus_in_type sync_a;
    usb_setup_ep_pkg::lbus_in_type sync_b;
    logic rd_seen;
    logic wr_seen;
    logic [3:0][7:0] setup;
    logic [3:0][5:0] sticky;
    usb_setup_ep_pkg::fifo_word_type [1:0] fifo;
    logic [1:0] fifo_vld;
    logic [15:0] rdata;
    logic oe_n;
    logic rx_ready;
    usb_setup_ep_pkg::ep_num_type rx_ep;
  } state_type;

  state_type cur_ff;
  state_type nxt_cur_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Buffer flags per endpoint, from the visible buffer only

  logic [3:0] buf_full;
  logic [3:0] buf_empty;

  genvar e;
  generate
    for (e = 0; e < `NUM_ENDPOINTS; e++)
    begin : g_flags
      logic at_max;
      logic at_zero;
      assign at_max = (buf_stat[e].count == ep_cfg[e].max_packet_size);
      assign at_zero = (buf_stat[e].count == 11'h000);
      // IN: full when packet complete or nothing free; OUT: full packet ready
      assign buf_full[e] = ep_cfg[e].dir_in ? (at_max | ~buf_stat[e].local_avail)
                                            : (at_max & buf_stat[e].local_avail);
      // IN: free space to write; OUT: nothing left to read
      assign buf_empty[e] = ep_cfg[e].dir_in ? (at_zero & buf_stat[e].local_avail)
                                             : (at_zero | ~buf_stat[e].local_avail);
      // Engine must NAK OUT data while the flag stands
      assign nak_out[e] = cur_ff.sticky[e][`BIT_NAK_OUT];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic rd_active;
  logic wr_active;
  logic rd_start;
  logic wr_start;
  logic [7:0] bus_addr;
  logic [15:0] bus_wdata;
  usb_setup_ep_pkg::ep_num_type vis_ep;
  usb_setup_ep_pkg::fifo_word_type push_word;
  logic push;
  logic pop;
  logic short_pkt;

  always_comb
  begin
    nxt_cur_ff = cur_ff;

    // Two stages on every bus pin; only the second stage is looked at
    nxt_cur_ff.sync_a = lbus;
    nxt_cur_ff.sync_b = cur_ff.sync_a;

    rd_active = ~cur_ff.sync_b.cs_n & ~cur_ff.sync_b.rd_n;
    wr_active = ~cur_ff.sync_b.cs_n & ~cur_ff.sync_b.wr_n;
    rd_start = rd_active & ~cur_ff.rd_seen;
    wr_start = wr_active & ~cur_ff.wr_seen;
    nxt_cur_ff.rd_seen = rd_active;
    nxt_cur_ff.wr_seen = wr_active;
    bus_addr = cur_ff.sync_b.addr;
    bus_wdata = cur_ff.sync_b.data;

    // DMA steering overrides the page for data and buffer flags only
    vis_ep = dma_enable ? dma_ep : page_sel;

    // Setup capture replaces all four bytes at once
    if (setup_cap.valid)
    begin
      nxt_cur_ff.setup[0] = setup_cap.index[7:0];
      nxt_cur_ff.setup[1] = setup_cap.index[15:8];
      nxt_cur_ff.setup[2] = setup_cap.length[7:0];
      nxt_cur_ff.setup[3] = setup_cap.length[15:8];
    end

    // Sticky status: clear mask first, then events, so an event never drops
    short_pkt = (usb_evt.data_rx | usb_evt.data_tx) &
                (usb_evt.pkt_len < ep_cfg[usb_evt.ep].max_packet_size);
    for (int i = 0; i < `NUM_ENDPOINTS; i++)
    begin
      logic [5:0] clr;
      logic [5:0] set;
      clr = 6'h00;
      set = 6'h00;
      // Software clears act on the paged endpoint; zeros and bits 7:6 ignored
      if (wr_start && bus_addr == `OFS_ENDPOINT_STATUS_LOW && page_sel == 2'(i))
      begin
        clr = bus_wdata[5:0];
      end
      if (rsp_clr_nak[i])
      begin
        clr[`BIT_NAK_OUT] = 1'b1;
      end
      if (rsp_set_nak[i])
      begin
        set[`BIT_NAK_OUT] = 1'b1;
      end
      if (usb_evt.ep == 2'(i))
      begin
        if (usb_evt.data_rx && short_pkt && ep_cfg[i].nak_out_mode)
        begin
          set[`BIT_NAK_OUT] = 1'b1;
        end
        set[`BIT_SHORT_PKT] = short_pkt;
        set[`BIT_PKT_RECEIVED] = usb_evt.data_rx;
        set[`BIT_PKT_SENT] = usb_evt.data_tx;
        set[`BIT_OUT_TOKEN] = usb_evt.out_token | (usb_evt.ping & usb_evt.high_speed);
        set[`BIT_IN_TOKEN] = usb_evt.in_token;
      end
      nxt_cur_ff.sticky[i] = (cur_ff.sticky[i] & ~clr) | set;
    end

    // Two entry buffer between data port writes and the packet buffer
    push_word.ep = vis_ep;
    push_word.two_bytes = bus16;
    push_word.data = bus16 ? bus_wdata : {8'h00, bus_wdata[7:0]};
    pop = cur_ff.fifo_vld[0] & tx_ready;
    push = wr_start & (bus_addr == `OFS_ENDPOINT_DATA_PORT) & (~cur_ff.fifo_vld[1] | pop);
    if (pop)
    begin
      nxt_cur_ff.fifo[0] = cur_ff.fifo[1];
      nxt_cur_ff.fifo_vld = {1'b0, cur_ff.fifo_vld[1]};
    end
    if (push)
    begin
      if (!nxt_cur_ff.fifo_vld[0])
      begin
        nxt_cur_ff.fifo[0] = push_word;
        nxt_cur_ff.fifo_vld[0] = 1'b1;
      end
      else
      begin
        nxt_cur_ff.fifo[1] = push_word;
        nxt_cur_ff.fifo_vld[1] = 1'b1;
      end
    end

    // Read side: data captured at the strobe edge, driven while strobe holds
    nxt_cur_ff.rx_ready = 1'b0;
    nxt_cur_ff.oe_n = ~rd_active;
    if (rd_start)
    begin
      unique case (bus_addr)
        `OFS_SETUP_INDEX_LOW: nxt_cur_ff.rdata = {8'h00, cur_ff.setup[0]};
        `OFS_SETUP_INDEX_HIGH: nxt_cur_ff.rdata = {8'h00, cur_ff.setup[1]};
        `OFS_SETUP_LENGTH_LOW: nxt_cur_ff.rdata = {8'h00, cur_ff.setup[2]};
        `OFS_SETUP_LENGTH_HIGH: nxt_cur_ff.rdata = {8'h00, cur_ff.setup[3]};
        `OFS_ENDPOINT_STATUS_LOW:
        begin
          // Flags follow DMA endpoint; sticky bits follow the page
          nxt_cur_ff.rdata = {8'h00, buf_full[vis_ep], buf_empty[vis_ep], cur_ff.sticky[page_sel]};
        end
        `OFS_ENDPOINT_DATA_PORT:
        begin
          // Empty buffer stream reads as zero rather than stalling the bus
          if (rx_valid)
          begin
            nxt_cur_ff.rdata = bus16 ? rx_data : {8'h00, rx_data[7:0]};
            nxt_cur_ff.rx_ready = 1'b1;
          end
          else
          begin
            nxt_cur_ff.rdata = `RST_ENDPOINT_DATA;
          end
          nxt_cur_ff.rx_ep = vis_ep;
        end
        default: nxt_cur_ff.rdata = `RST_UNMAPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Bus strobes idle high, address and data zero; empty flag value follows the buffer manager
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cur_ff.sync_a <= {1'b1, 1'b1, 1'b1, 8'h00, 16'h0000};
      cur_ff.sync_b <= {1'b1, 1'b1, 1'b1, 8'h00, 16'h0000};
      cur_ff.rd_seen <= 1'b0;
      cur_ff.wr_seen <= 1'b0;
      cur_ff.setup <= {4{`RST_SETUP_BYTE}};
      cur_ff.sticky <= {4{`RST_STICKY}};
      cur_ff.fifo <= '0;
      cur_ff.fifo_vld <= 2'h0;
      cur_ff.rdata <= `RST_ENDPOINT_DATA;
      cur_ff.oe_n <= 1'b1;
      cur_ff.rx_ready <= 1'b0;
      cur_ff.rx_ep <= 2'h0;
    end
    else
    begin
      cur_ff <= nxt_cur_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each a flip-flop field

  assign data_out = cur_ff.rdata;
  assign data_oe_n = cur_ff.oe_n;
  assign bus_wait = cur_ff.fifo_vld[1];
  assign tx_valid = cur_ff.fifo_vld[0];
  assign tx_word = cur_ff.fifo[0];
  assign rx_ready = cur_ff.rx_ready;
  assign rx_ep = cur_ff.rx_ep;

endmodule

`default_nettype wire

//--- bench/usb_setup_ep_chk.sv
`default_nettype none
module usb_setup_ep_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire usb_setup_ep_pkg::lbus_in_type lbus,
  input wire usb_setup_ep_pkg::ep_config_type [3:0] ep_cfg,
  input wire usb_setup_ep_pkg::usb_event_type usb_evt,
  input wire logic [3:0] rsp_set_nak,
  input wire logic [3:0] rsp_clr_nak,
  input wire logic tx_ready,
  input wire logic data_oe_n,
  input wire logic bus_wait,
  input wire logic tx_valid,
  input wire usb_setup_ep_pkg::fifo_word_type tx_word,
  input wire logic [3:0] nak_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Strobe decode at the pins, before the synchronisers
  logic rd_low;
  logic wr_port;
  assign rd_low = !lbus.cs_n && !lbus.rd_n;
  assign wr_port = !lbus.cs_n && !lbus.wr_n && lbus.addr == 8'h05;
  sequence s_rd_held;
    rd_low [*6];
  endsequence
  sequence s_wr_start;
    wr_port && !$past(wr_port) && !tx_valid;
  endsequence
  ////////////////////////////////////////////////////////////
  property p_oe_on;
    s_rd_held |-> !data_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("read not driven");
  property p_oe_off;
    !rd_low [*6] |-> data_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven when idle");
  property p_push;
    s_wr_start |-> ##[3:5] tx_valid;
  endproperty
  a_push: assert property (p_push) else $error("write not queued");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_word);
  endproperty
  a_hold: assert property (p_hold) else $error("word lost on stall");
  property p_wait;
    bus_wait |-> tx_valid;
  endproperty
  a_wait: assert property (p_wait) else $error("wait with empty buffer");
  // Short OUT packet in NAK mode; a clear in the same cycle loses
  property p_nak_evt;
    usb_evt.data_rx && usb_evt.pkt_len < ep_cfg[usb_evt.ep].max_packet_size && ep_cfg[usb_evt.ep].nak_out_mode
      |=> nak_out[$past(usb_evt.ep)];
  endproperty
  a_nak_evt: assert property (p_nak_evt) else $error("nak flag not set");
  property p_rsp_set;
    rsp_set_nak != 4'h0 |=> (nak_out & $past(rsp_set_nak)) == $past(rsp_set_nak);
  endproperty
  a_rsp_set: assert property (p_rsp_set) else $error("response set ignored");
  property p_rsp_clr;
    rsp_clr_nak[0] && !rsp_set_nak[0] && !usb_evt.data_rx |=> !nak_out[0];
  endproperty
  a_rsp_clr: assert property (p_rsp_clr) else $error("response clear ignored");
endmodule
`default_nettype wire

//--- bench/usb_ep_buf_model.sv
`default_nettype none
module usb_ep_buf_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic tx_valid,
  input wire usb_setup_ep_pkg::fifo_word_type tx_word,
  input wire logic rx_ready,
  output logic tx_ready,
  output logic rx_valid,
  output logic [15:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  usb_setup_ep_pkg::fifo_word_type got [$];
  // Sink stalls only when the bench says so
  assign tx_ready = !stall;
  // Source counts up on every pop, so a missed pop shows
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_valid <= 1'b0;
      rx_data <= 16'hBEE0;
    end
    else
    begin
      rx_valid <= 1'b1;
      if (tx_valid && tx_ready)
        got.push_back(tx_word);
      if (rx_ready)
        rx_data <= rx_data + 16'h0001;
    end
  end
endmodule
`default_nettype wire

//--- bench/test_usb_setup_ep_regs.sv
`default_nettype none
module test_usb_setup_ep_regs;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [5:0] k; logic [10:0] len; logic [7:0] exp;} row_type;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  usb_setup_ep_pkg::lbus_in_type lb = {3'h7, 8'h00, 16'h0000};
  logic bus16 = 1'b1;
  usb_setup_ep_pkg::ep_num_type page_sel = 2'h0;
  logic dma_enable = 1'b0;
  usb_setup_ep_pkg::ep_num_type dma_ep = 2'h0;
  usb_setup_ep_pkg::ep_config_type [3:0] ep_cfg = {13'h1040, 13'h0040, 13'h1040, 13'h0840};
  usb_setup_ep_pkg::buf_status_type [3:0] buf_stat = {12'h800, 12'h840, 12'h000, 12'h800};
  usb_setup_ep_pkg::usb_event_type usb_evt = '0;
  usb_setup_ep_pkg::setup_capture_type setup_cap = '0;
  logic [3:0] rsp_set_nak = 4'h0;
  logic [3:0] rsp_clr_nak = 4'h0;
  logic stall = 1'b0;
  logic tx_ready, rx_valid, rx_ready, data_oe_n, bus_wait, tx_valid;
  logic [15:0] rx_data, data_out, q;
  usb_setup_ep_pkg::fifo_word_type tx_word;
  usb_setup_ep_pkg::ep_num_type rx_ep;
  logic [3:0] nak_out;
  int errors = 0;
  int tests_run = 0;
  // Event bits: in, out, ping, high speed, received, sent
  row_type rows [8] = '{'{6'h20, 11'h040, 8'h41}, '{6'h10, 11'h040, 8'h42}, '{6'h0C, 11'h040, 8'h42},
    '{6'h08, 11'h040, 8'h40}, '{6'h01, 11'h040, 8'h44}, '{6'h01, 11'h008, 8'h54},
    '{6'h02, 11'h040, 8'h48}, '{6'h02, 11'h008, 8'h78}};
  always #12.5 clk = ~clk;
  usb_setup_ep_regs dut (.clk(clk), .resetn(resetn), .lbus(lb), .bus16(bus16), .page_sel(page_sel),
    .dma_enable(dma_enable), .dma_ep(dma_ep), .ep_cfg(ep_cfg), .buf_stat(buf_stat), .usb_evt(usb_evt),
    .setup_cap(setup_cap), .rsp_set_nak(rsp_set_nak), .rsp_clr_nak(rsp_clr_nak), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .data_out(data_out), .data_oe_n(data_oe_n), .bus_wait(bus_wait),
    .tx_valid(tx_valid), .tx_word(tx_word), .rx_ready(rx_ready), .rx_ep(rx_ep), .nak_out(nak_out));
  usb_ep_buf_model buf_model (.clk(clk), .resetn(resetn), .stall(stall), .tx_valid(tx_valid),
    .tx_word(tx_word), .rx_ready(rx_ready), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe held six cycles; data kept past the synchronisers, then scrambled
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    lb = {1'b0, wr, !wr, a, d};
    repeat (6) @(negedge clk);
    q = data_out;
    lb = {3'h7, a, d};
    repeat (3) @(negedge clk);
    lb.data = ~d;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    chk(q, exp);
  endtask
  task automatic pulse(input logic [5:0] k, input logic [10:0] len);
    @(negedge clk);
    usb_evt = {2'h0, k, len};
    @(negedge clk);
    usb_evt = '0;
  endtask
  task automatic wait_got(input int n);
    int i;
    for (i = 0; i < 50 && buf_model.got.size() < n; i++)
      @(negedge clk);
    if (buf_model.got.size() < n)
    begin
      errors++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++)
      rd(8'h44 + 8'(i), 16'h0000);
    rd(8'h06, 16'h0040);
    $display("reset test done");
    foreach (rows[i])
    begin
      pulse(rows[i].k, rows[i].len);
      rd(8'h06, {8'h00, rows[i].exp});
      bus(1'b1, 8'h06, 16'h003F);
      rd(8'h06, 16'h0040);
    end
    $display("status table done");
    @(negedge clk);
    setup_cap = {1'b1, 16'hA1B2, 16'hC3D4};
    @(negedge clk);
    setup_cap = '0;
    bus(1'b1, 8'h44, 16'h00FF);
    rd(8'h44, 16'h00B2);
    rd(8'h45, 16'h00A1);
    rd(8'h46, 16'h00D4);
    rd(8'h47, 16'h00C3);
    pulse(6'h20, 11'h040);
    bus(1'b1, 8'h06, 16'h00C0);
    rd(8'h06, 16'h0041);
    rsp_set_nak = 4'h1;
    @(negedge clk);
    rsp_set_nak = 4'h0;
    chk({12'h000, nak_out}, 16'h0001);
    rd(8'h06, 16'h0061);
    rsp_clr_nak = 4'h1;
    @(negedge clk);
    rsp_clr_nak = 4'h0;
    rd(8'h06, 16'h0041);
    // Clear of all sticky bits lands on the same edge as an OUT token
    fork
      bus(1'b1, 8'h06, 16'h003F);
      begin
        repeat (3) @(negedge clk);
        usb_evt = {2'h0, 6'h10, 11'h040};
        @(negedge clk);
        usb_evt = '0;
      end
    join
    rd(8'h06, 16'h0042);
    $display("setup and nak test done");
    // Page first, then access; endpoint 0 keeps its token bit
    for (int p = 1; p < 4; p++)
    begin
      page_sel = 2'(p);
      rd(8'h06, (p == 3) ? 16'h0040 : 16'h0080);
    end
    page_sel = 2'h1;
    dma_enable = 1'b1;
    rd(8'h06, 16'h0040);
    dma_ep = 2'h2;
    stall = 1'b1;
    bus(1'b1, 8'h05, 16'h1234);
    bus(1'b1, 8'h05, 16'h5678);
    chk({15'h0000, bus_wait}, 16'h0001);
    stall = 1'b0;
    wait_got(2);
    chk(buf_model.got[0].data, 16'h1234);
    chk({14'h0000, buf_model.got[0].ep}, 16'h0002);
    chk(buf_model.got[1].data, 16'h5678);
    bus16 = 1'b0;
    bus(1'b1, 8'h05, 16'hAB56);
    wait_got(3);
    chk({7'h00, buf_model.got[2].two_bytes, buf_model.got[2].data[7:0]}, 16'h0056);
    bus16 = 1'b1;
    rd(8'h05, 16'hBEE0);
    chk({14'h0000, rx_ep}, 16'h0002);
    bus16 = 1'b0;
    rd(8'h05, 16'h00E1);
    $display("paging and data port done");
    complete_run();
  end
endmodule
bind usb_setup_ep_regs usb_setup_ep_chk chk (.clk(clk), .resetn(resetn), .lbus(lbus), .ep_cfg(ep_cfg),
  .usb_evt(usb_evt), .rsp_set_nak(rsp_set_nak), .rsp_clr_nak(rsp_clr_nak), .tx_ready(tx_ready),
  .data_oe_n(data_oe_n), .bus_wait(bus_wait), .tx_valid(tx_valid), .tx_word(tx_word), .nak_out(nak_out));
`default_nettype wire
